/* rtl/qpl_rx.sv */
// quad pixel video link receiver with apb register slave
// What this block does
// - the link clock lane carries 010101 and is only checked; link_clk clocks the receiver.
// - alignment starts only on the strobe together with the pattern.
// - each pixel spans four lanes red, red/green, green/blue, blue.
// - lane 8 holds vsync bit 5, hsync bit 3, enable bit 1, others high.
// - mode 01h is dual pixel: only lanes 4 to 12 carry data.
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "qpl_cfg.svh"
module qpl_rx (
    input  wire logic             pclk,          // bus clock
    input  wire logic             presetn,       // async reset, low
    input  wire logic             clk_en,        // freezes state when low
    input  wire qpl_pkg::qpl_addr_t paddr,       // apb address
    input  wire logic             psel,          // apb select
    input  wire logic             penable,       // apb enable
    input  wire logic             pwrite,        // apb direction
    input  wire qpl_pkg::qpl_word_t pwdata,      // apb write data
    output logic [31:0]           prdata,        // apb read data
    output logic                  pready,        // apb ready
    output logic                  pslverr,       // apb error
    input  wire logic             link_clk,      // forwarded link clock
    input  wire qpl_pkg::qpl_lanes_t lane_data,  // 17 lanes of 6 bits
    input  wire qpl_pkg::qpl_lane_t clock_lane,  // clock lane word
    input  wire logic             align_strobe,  // cmos alignment strobe
    output logic [95:0]           pixel_out,     // pixels 3..0
    output logic                  pixel_valid,   // video data enable
    output logic                  vsync_out,     // vertical sync
    output logic                  hsync_out,     // horizontal sync
    output logic                  lanes_aligned  // link side align state
);
    import qpl_pkg::*;

    // ****************************************************************
    // bus side registers
    // ****************************************************************
    logic             pready_q;
    logic             pslverr_q;
    logic [31:0]      prdata_q;
    logic             rx_en_q;
    logic [7:0]       mode_q;
    logic [3:1]       sticky_q;
    logic [15:0]      acount_q;
    logic [`QPL_EV_N-1:0] ev_a_q, ev_b_q, ev_c_q;
    logic [`QPL_EV_N-1:0] ev_t_q;
    logic             aligned_q;
    logic             dual_q;
    logic             al_s1_q, al_s2_q;
    logic             hit;
    logic [31:0]      rdata_d;

    wire acc       = psel & penable;
    wire start     = acc & ~pready_q;
    wire take      = acc & pready_q;
    wire wr        = take & pwrite & hit;
    wire wr_ctrl   = wr & (paddr == `QPL_OFS_CTRL);
    wire wr_mode   = wr & (paddr == `QPL_OFS_MODE);
    wire wr_stat   = wr & (paddr == `QPL_OFS_STATUS);
    wire [`QPL_EV_N-1:0] ev = ev_b_q ^ ev_c_q;
    wire [3:1] clr = wr_stat ? pwdata[3:1] : 3'h0;

    always_comb begin
        hit     = 1'b1;
        rdata_d = 32'h0000_0000;
        if (paddr == `QPL_OFS_CTRL) begin
            rdata_d[`QPL_CTRL_EN] = rx_en_q;
        end else if (paddr == `QPL_OFS_MODE) begin
            rdata_d[7:0] = mode_q;
        end else if (paddr == `QPL_OFS_STATUS) begin
            rdata_d[3:0] = {sticky_q, al_s2_q};
        end else if (paddr == `QPL_OFS_ACOUNT) begin
            rdata_d[15:0] = acount_q;
        end else begin
            hit = 1'b0;
        end
    end

    // one wait state: ready is a registered one-cycle answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else if (clk_en) begin
            pready_q  <= start;
            pslverr_q <= start & ~hit;
            if (start) begin
                prdata_q <= rdata_d;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_en_q  <= `QPL_CTRL_RST;
            mode_q   <= `QPL_MODE_RST;
            dual_q   <= (`QPL_MODE_RST == `QPL_MODE_DUAL);
        end else if (clk_en) begin
            if (wr_ctrl) begin
                rx_en_q <= pwdata[`QPL_CTRL_EN];
            end
            // registered so no comparator glitch reaches the link side
            if (wr_mode) begin
                mode_q <= pwdata[7:0];
                dual_q <= (pwdata[7:0] == `QPL_MODE_DUAL);
            end
        end
    end

    // set wins over a write-one clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sticky_q <= 3'h0;
            acount_q <= 16'h0000;
        end else if (clk_en) begin
            sticky_q <= (sticky_q & ~clr) | ev[`QPL_EV_CLK:`QPL_EV_NOPAT];
            if (ev[`QPL_EV_ALIGN]) begin
                acount_q <= acount_q + 16'h0001;
            end
        end
    end

    // link events arrive as toggles; first stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev_a_q  <= '0;
            ev_b_q  <= '0;
            ev_c_q  <= '0;
            al_s1_q <= 1'b0;
            al_s2_q <= 1'b0;
        end else if (clk_en) begin
            ev_a_q  <= ev_t_q;
            ev_b_q  <= ev_a_q;
            ev_c_q  <= ev_b_q;
            al_s1_q <= aligned_q;
            al_s2_q <= al_s1_q;
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    // ****************************************************************
    // link side
    // ****************************************************************
    logic [1:0]       lrst_q;
    logic [2:0]       cfg_s1_q, cfg_s2_q;
    logic [2:0]       stb_s_q;
    logic             strobe_q;
    qpl_lanes_t       pipe_q [`QPL_LANE_DLY];
    qpl_quad_t        pix_q;
    logic             valid_q, vs_q, hs_q;
    qpl_align_st_t    al_st_q;
    qpl_pixel_t       pix [4];

    // reset leaves the link domain only on a link clock edge
    wire lrst_n = lrst_q[1];
    always_ff @(posedge link_clk or negedge presetn) begin
        if (!presetn) begin
            lrst_q <= 2'h0;
        end else begin
            lrst_q <= {lrst_q[0], 1'b1};
        end
    end

    // enable, receiver on and dual select cross as levels
    wire ce_l  = cfg_s2_q[0];
    wire en_l  = cfg_s2_q[1];
    wire dual_l = cfg_s2_q[2];
    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            cfg_s1_q <= 3'h0;
            cfg_s2_q <= 3'h0;
        end else begin
            cfg_s1_q <= {dual_q, rx_en_q, clk_en};
            cfg_s2_q <= cfg_s1_q;
        end
    end

    // lanes are delayed to line up with the filtered strobe
    qpl_lanes_t d;
    assign d = pipe_q[`QPL_LANE_DLY-1];
    wire qpl_lane_t sync_w  = d[`QPL_SYNC_LANE*6 +: 6];
    wire qpl_lane_t algn_w  = d[`QPL_ALIGN_LANE*6 +: 6];
    wire de_w    = sync_w[`QPL_DE_BIT];
    wire pat_hit = (algn_w == `QPL_ALIGN_WORD);
    wire sync_bad = (sync_w & `QPL_SYNC_ONES) != `QPL_SYNC_ONES;
    wire clk_bad  = (clock_lane != `QPL_CLK_WORD);

    // each pixel is four lanes, most significant lane is red 7:2
    genvar p;
    generate
        for (p = 0; p < 4; p++) begin : g_pix
            localparam int B = (p == 0) ? `QPL_P0_BASE :
                               (p == 1) ? `QPL_P1_LANE :
                               (p == 2) ? `QPL_P2_LANE : `QPL_P3_LANE;
            assign pix[p] = d[B*6 +: 24];
        end
    endgenerate

    // lane 7 carries the reference under the strobe, so mask red 7:2
    wire qpl_pixel_t pix0_m = strobe_q ? {6'h00, pix[0][17:0]} : pix[0];
    wire [47:0] upper = dual_l ? 48'h0000_0000_0000 : {pix[3], pix[2]};

    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            stb_s_q  <= 3'h0;
            strobe_q <= 1'b0;
            for (int i = 0; i < `QPL_LANE_DLY; i++) begin
                // idle word keeps the sync check quiet while filling
                pipe_q[i] <= `QPL_LANES_IDLE;
            end
        end else if (ce_l) begin
            stb_s_q <= {stb_s_q[1:0], align_strobe};
            if (stb_s_q[1] == stb_s_q[2]) begin
                strobe_q <= stb_s_q[2];
            end
            pipe_q[0] <= lane_data;
            for (int i = 1; i < `QPL_LANE_DLY; i++) begin
                pipe_q[i] <= pipe_q[i-1];
            end
        end
    end

    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            pix_q   <= '0;
            valid_q <= 1'b0;
            vs_q    <= 1'b0;
            hs_q    <= 1'b0;
        end else if (ce_l) begin
            pix_q   <= {upper, pix[1], pix0_m};
            valid_q <= en_l & de_w & ~strobe_q;
            vs_q    <= en_l & sync_w[`QPL_VS_BIT];
            hs_q    <= en_l & sync_w[`QPL_HS_BIT];
        end
    end

    // one alignment per strobe, only with pattern and enable low
    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            al_st_q   <= QPL_AL_IDLE;
            aligned_q <= 1'b0;
            ev_t_q    <= '0;
        end else if (ce_l) begin
            if (!en_l) begin
                aligned_q <= 1'b0;
            end
            if (en_l && sync_bad) begin
                ev_t_q[`QPL_EV_SYNC] <= ~ev_t_q[`QPL_EV_SYNC];
            end
            if (en_l && clk_bad) begin
                ev_t_q[`QPL_EV_CLK] <= ~ev_t_q[`QPL_EV_CLK];
            end
            case (al_st_q)
                QPL_AL_IDLE: begin
                    if (strobe_q && en_l) begin
                        al_st_q <= QPL_AL_STROBE;
                        if (pat_hit && !de_w) begin
                            aligned_q <= 1'b1;
                            ev_t_q[`QPL_EV_ALIGN] <= ~ev_t_q[`QPL_EV_ALIGN];
                        end else begin
                            ev_t_q[`QPL_EV_NOPAT] <= ~ev_t_q[`QPL_EV_NOPAT];
                        end
                    end
                end
                default: begin
                    if (!strobe_q) begin
                        al_st_q <= QPL_AL_IDLE;
                    end
                end
            endcase
        end
    end

    assign pixel_out     = pix_q;
    assign pixel_valid   = valid_q;
    assign vsync_out     = vs_q;
    assign hsync_out     = hs_q;
    assign lanes_aligned = aligned_q;

    // ****************************************************************
    // checks
    // ****************************************************************
    apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && start |=> pready_q ##1 !pready_q)
        else $error("ready not a single registered answer");
    unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
        pready_q && !hit && acc |-> pslverr_q)
        else $error("unmapped access without error");
    mode_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && wr_mode |=> mode_q == $past(pwdata[7:0]))
        else $error("mode write lost");
    sticky_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        sticky_q[`QPL_ST_SYNC] && !wr_stat |=> sticky_q[`QPL_ST_SYNC])
        else $error("sticky flag dropped");
    align_count_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && ev[`QPL_EV_ALIGN] |=> acount_q == $past(acount_q) + 16'h1)
        else $error("align count missed");
    dual_upper_a: assert property (
        @(posedge link_clk) disable iff (!lrst_n)
        ce_l && dual_l |=> pix_q[95:48] == 48'h0)
        else $error("dual mode upper pixels not zero");
    strobe_mask_a: assert property (
        @(posedge link_clk) disable iff (!lrst_n)
        ce_l && strobe_q |=> !valid_q && pix_q[23:18] == 6'h00)
        else $error("video shown under strobe");
    align_pat_a: assert property (
        @(posedge link_clk) disable iff (!lrst_n)
        $changed(ev_t_q[`QPL_EV_ALIGN])
        |-> $past(pat_hit && !de_w && strobe_q))
        else $error("alignment without pattern");
    sync_fields_a: assert property (
        @(posedge link_clk) disable iff (!lrst_n)
        ce_l && en_l |=> vs_q == $past(sync_w[`QPL_VS_BIT])
            && hs_q == $past(sync_w[`QPL_HS_BIT]))
        else $error("sync lane decode wrong");
endmodule
`default_nettype wire

/* rtl/qpl_cfg.svh */
// constants of the quad pixel link receiver: offsets, fields, patterns
`ifndef QPL_CFG_SVH
`define QPL_CFG_SVH
// lane layout
`define QPL_LANE_W      6
`define QPL_NUM_LANES   17
`define QPL_ALIGN_LANE  7
`define QPL_SYNC_LANE   8
`define QPL_P0_LANE     0
`define QPL_P1_LANE     9
`define QPL_P2_LANE     0
`define QPL_P3_LANE     13
`define QPL_P0_BASE     4
`define QPL_VS_BIT      5
`define QPL_HS_BIT      3
`define QPL_DE_BIT      1
`define QPL_SYNC_ONES   6'h15
`define QPL_CLK_WORD    6'h15
`define QPL_ALIGN_WORD  6'h20
`define QPL_LANE_DLY    3
`define QPL_LANES_IDLE  102'h15_0000_0000_0000
// modes
`define QPL_MODE_DUAL   8'h01
`define QPL_MODE_RST    8'h00
// register map (byte addresses)
`define QPL_OFS_CTRL    12'h000
`define QPL_OFS_MODE    12'h004
`define QPL_OFS_STATUS  12'h008
`define QPL_OFS_ACOUNT  12'h00C
`define QPL_CTRL_EN     0
`define QPL_CTRL_RST    1'h1
`define QPL_ST_ALIGNED  0
`define QPL_ST_NOPAT    1
`define QPL_ST_SYNC     2
`define QPL_ST_CLK      3
// link events crossing to the bus side
`define QPL_EV_ALIGN    0
`define QPL_EV_NOPAT    1
`define QPL_EV_SYNC     2
`define QPL_EV_CLK      3
`define QPL_EV_N        4
`endif

/* rtl/qpl_pkg.sv */
// types shared by the quad pixel link receiver
package qpl_pkg;
    typedef logic [5:0]   qpl_lane_t;
    typedef logic [23:0]  qpl_pixel_t;
    typedef logic [101:0] qpl_lanes_t;
    typedef logic [95:0]  qpl_quad_t;
    typedef logic [11:0]  qpl_addr_t;
    typedef logic [31:0]  qpl_word_t;
    typedef enum logic {QPL_AL_IDLE, QPL_AL_STROBE} qpl_align_st_t;
endpackage

/* verif/qpl_host_tx.sv */
// host side link transmitter model that drives the receiver lanes
`timescale 1ns/10ps
`default_nettype none
module qpl_host_tx (
    input  wire logic                vclk,         // link clock
    input  wire logic                rstn,         // async reset, low
    input  wire qpl_pkg::qpl_quad_t  pix_in,       // pixels 3..0
    input  wire logic                vs_in,        // vertical sync
    input  wire logic                hs_in,        // horizontal sync
    input  wire logic                video_enable_in,        // data enable
    input  wire logic                en_in,        // enable to delay
    input  wire logic                vsync_polarity_select,        // 1 keeps vsync as is
    input  wire logic                no_pattern,   // fault: strobe only
    output var qpl_pkg::qpl_lanes_t  lane_q,       // registered lanes
    output var qpl_pkg::qpl_lane_t   clk_word,     // clock lane word
    output var logic                 align_strobe, // cmos strobe
    output var logic                 en_out        // delayed enable
);
    import qpl_pkg::*;
    logic [8:0] vs_q;
    logic [4:0] en_q;
    logic       win;
    logic [5:0] red_hi;
    // ************************************************************
    // strobe nested inside the wider pattern window
    // ************************************************************
    assign align_strobe = vs_q[3] & ~vs_q[6];
    // fault input only drops the pattern, the strobe still goes out
    assign win      = vs_q[0] & ~vs_q[8] & ~no_pattern;
    assign red_hi   = win ? 6'h20 : pix_in[23:18];
    assign clk_word = 6'h15;
    assign en_out   = en_q[4];
    always_ff @(posedge vclk or negedge rstn) begin
        if (!rstn) begin
            vs_q   <= '0;
            en_q   <= '0;
            lane_q <= '0;
        end else begin
            vs_q   <= {vs_q[7:0], vs_in ^ ~vsync_polarity_select};
            en_q   <= {en_q[3:0], en_in};
            lane_q <= {pix_in[95:72], pix_in[47:24],
                       vs_in, 1'h1, hs_in, 1'h1, video_enable_in, 1'h1,
                       red_hi, pix_in[17:0], pix_in[71:48]};
        end
    end
endmodule
`default_nettype wire

/* verif/testbench.sv */
// self-checking bench: apb register traffic and host link video
`timescale 1ns/10ps
`default_nettype none
`include "qpl_cfg.svh"
module testbench;
    import qpl_pkg::*;
    logic        pclk, presetn, link_clk, psel, penable, pwrite;
    qpl_addr_t   paddr;
    qpl_word_t   pwdata, prdata;
    logic        pready, pslverr, vs, hs, de, no_pat, strobe, clk_en, aligned;
    logic [1:0]  fault;
    qpl_quad_t   pix, pixel_out;
    qpl_lanes_t  lane_data;
    qpl_lane_t   clock_lane;
    logic        pixel_valid, vsync_out, hsync_out;
    logic [97:0] pix_q[$];
    logic [97:0] reg_q[$];
    int          miscompares, samples_checked, cyc;
    qpl_rx dut_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link_clk(link_clk),
        .lane_data(lane_data ^ {53'h0, fault[1], 48'h0}),
        .clock_lane(clock_lane ^ {5'h0, fault[0]}), .align_strobe(strobe),
        .pixel_out(pixel_out), .pixel_valid(pixel_valid),
        .vsync_out(vsync_out), .hsync_out(hsync_out),
        .lanes_aligned(aligned));
    qpl_host_tx host_u (.vclk(link_clk), .rstn(presetn), .pix_in(pix),
        .vs_in(vs), .hs_in(hs), .video_enable_in(de), .en_in(de), .vsync_polarity_select(1'h1),
        .no_pattern(no_pat), .lane_q(lane_data), .clk_word(clock_lane),
        .align_strobe(strobe), .en_out());
    // ************************************************************
    // clocks, checking and closing
    // ************************************************************
    initial begin
        pclk = 1'h0;
        forever #25 pclk = ~pclk;
    end
    initial begin
        link_clk = 1'h0;
        #37;
        forever #80 link_clk = ~link_clk;
    end
    task automatic check(input logic [97:0] seen, input logic [97:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            end_of_test();
        end
    end
    // ************************************************************
    // drivers and monitors
    // ************************************************************
    task automatic xfer(input logic wr, input qpl_addr_t a,
                        input qpl_word_t d, input logic err,
                        input qpl_word_t rd);
        int n;
        n = 0;
        @(posedge pclk);
        reg_q.push_back({65'h0, err, rd});
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (n >= 20)
            miscompares++;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'h1) begin
            if (reg_q.size() == 0)
                check(98'h1, 98'h0);
            else
                check({65'h0, pslverr, pwrite ? 32'h0 : prdata},
                      reg_q.pop_front());
        end
    end
    task automatic frame(input int n, input logic dual, input logic keep);
        qpl_quad_t p;
        logic      h;
        repeat (n) begin
            @(posedge link_clk);
            p = {$urandom, $urandom, $urandom};
            h = 1'($urandom);
            pix <= p;
            hs  <= h;
            de  <= 1'h1;
            if (keep)
                pix_q.push_back({1'h0, h, dual ? {48'h0, p[47:0]} : p});
        end
        @(posedge link_clk);
        de <= 1'h0;
        hs <= 1'h0;
        repeat (8) @(posedge link_clk);
    endtask
    always @(posedge link_clk) begin
        if (pixel_valid === 1'h1) begin
            if (pix_q.size() == 0)
                check(98'h1, 98'h0);
            else
                check({vsync_out, hsync_out, pixel_out},
                      pix_q.pop_front());
        end
    end
    task automatic blank_align(input logic bad);
        @(posedge link_clk);
        no_pat <= bad;
        vs     <= 1'h1;
        repeat (10) @(posedge link_clk);
        check(98'(vsync_out), 98'h1);
        vs <= 1'h0;
        repeat (24) @(posedge link_clk);
        check(98'(vsync_out), 98'h0);
        no_pat <= 1'h0;
    endtask
    initial begin
        void'($urandom(94));
        {psel, penable, pwrite, vs, hs, de, no_pat} = '0;
        clk_en = 1'h1;
        fault = 2'h0;
        paddr = '0;
        pwdata = '0;
        pix = '0;
        cyc = 0;
        miscompares = 0;
        samples_checked = 0;
        presetn = 1'h0;
        repeat (6) @(posedge pclk);
        presetn <= 1'h1;
        repeat (8) @(posedge link_clk);
        // a frozen block only stalls the answer, the data stays right
        fork
            xfer(1'h0, `QPL_OFS_CTRL, 32'h0, 1'h0, 32'h1);
            begin
                @(posedge pclk);
                clk_en <= 1'h0;
                repeat (4) @(posedge pclk);
                clk_en <= 1'h1;
            end
        join
        xfer(1'h0, `QPL_OFS_MODE, 32'h0, 1'h0, 32'h0);
        xfer(1'h0, `QPL_OFS_ACOUNT, 32'h0, 1'h0, 32'h0);
        xfer(1'h0, 12'h010, 32'h0, 1'h1, 32'h0);
        xfer(1'h1, 12'hFFC, 32'hFFFF_FFFF, 1'h1, 32'h0);
        // strobe with no pattern must not count as an alignment
        blank_align(1'h1);
        xfer(1'h0, `QPL_OFS_STATUS, 32'h0, 1'h0, 32'h2);
        check(98'(aligned), 98'h0);
        xfer(1'h0, `QPL_OFS_ACOUNT, 32'h0, 1'h0, 32'h0);
        xfer(1'h1, `QPL_OFS_STATUS, 32'h2, 1'h0, 32'h0);
        xfer(1'h0, `QPL_OFS_STATUS, 32'h0, 1'h0, 32'h0);
        frame(16, 1'h0, 1'h1);
        blank_align(1'h0);
        xfer(1'h0, `QPL_OFS_STATUS, 32'h0, 1'h0, 32'h1);
        check(98'(aligned), 98'h1);
        xfer(1'h0, `QPL_OFS_ACOUNT, 32'h0, 1'h0, 32'h1);
        xfer(1'h1, `QPL_OFS_MODE, 32'h1, 1'h0, 32'h0);
        xfer(1'h0, `QPL_OFS_MODE, 32'h0, 1'h0, 32'h1);
        repeat (6) @(posedge link_clk);
        frame(12, 1'h1, 1'h1);
        blank_align(1'h0);
        xfer(1'h0, `QPL_OFS_ACOUNT, 32'h0, 1'h0, 32'h2);
        // bad clock lane word and a low fixed-high sync bit
        @(posedge link_clk);
        fault <= 2'h3;
        repeat (4) @(posedge link_clk);
        fault <= 2'h0;
        repeat (6) @(posedge link_clk);
        xfer(1'h0, `QPL_OFS_STATUS, 32'h0, 1'h0, 32'hD);
        xfer(1'h1, `QPL_OFS_STATUS, 32'hC, 1'h0, 32'h0);
        xfer(1'h0, `QPL_OFS_STATUS, 32'h0, 1'h0, 32'h1);
        // any mode other than dual falls back to four pixels
        xfer(1'h1, `QPL_OFS_MODE, 32'h2, 1'h0, 32'h0);
        repeat (6) @(posedge link_clk);
        frame(8, 1'h0, 1'h1);
        xfer(1'h1, `QPL_OFS_CTRL, 32'h0, 1'h0, 32'h0);
        repeat (6) @(posedge link_clk);
        frame(8, 1'h0, 1'h0);
        xfer(1'h0, `QPL_OFS_STATUS, 32'h0, 1'h0, 32'h0);
        check(98'(aligned), 98'h0);
        repeat (10) @(posedge link_clk);
        check(98'(pix_q.size()), 98'h0);
        check(98'(reg_q.size()), 98'h0);
        end_of_test();
    end
endmodule
`default_nettype wire
